// [fcc_pkg.sv]
// package: register map, fields, commands and timing for the flash command controller
package fcc_pkg;
    // ==========================================
    // register offsets
    localparam logic [31:0] FCC_STATUS_ADDR  = 32'hFFFF0E00;
    localparam logic [31:0] FCC_MODE_ADDR    = 32'hFFFF0E04;
    localparam logic [31:0] FCC_CMD_ADDR     = 32'hFFFF0E08;
    localparam logic [31:0] FCC_DATA_ADDR    = 32'hFFFF0E0C;
    localparam logic [31:0] FCC_ADDR_ADDR    = 32'hFFFF0E10;
    localparam logic [31:0] FCC_SIG_ADDR     = 32'hFFFF0E18;
    localparam logic [31:0] FCC_PROT_ADDR    = 32'hFFFF0E1C;
    // ==========================================
    // field positions
    localparam int FCC_ST_PASS  = 0;
    localparam int FCC_ST_FAIL  = 1;
    localparam int FCC_ST_BUSY  = 2;
    localparam int FCC_ST_IRQ   = 3;
    localparam int FCC_MD_WREN  = 3;
    localparam int FCC_MD_IEN   = 4;
    // ==========================================
    // reset values, erased word value and highest valid address
    localparam logic [15:0] FCC_MODE_RST   = 16'h0000;
    localparam logic [7:0]  FCC_CMD_RST    = 8'h07;
    localparam logic [15:0] FCC_ADDR_RST   = 16'h0000;
    localparam logic [15:0] FCC_DATA_RST   = 16'h0000;
    localparam logic [23:0] FCC_SIG_RST    = 24'hFFFFFF;
    localparam logic [31:0] FCC_PROT_RST   = 32'h00000000;
    localparam logic [15:0] FCC_ERASED     = 16'hFFFF;
    localparam logic [15:0] FCC_ADDR_MAX   = 16'h77FF;
    // ==========================================
    // geometry: 16 kwords, 512-byte page = 256 words
    localparam int FCC_AW        = 14;
    localparam int FCC_PAGE_BITS = 8;
    localparam int FCC_USER_WORDS = 15360;
    // ==========================================
    // commands
    typedef enum logic [7:0] {
        FCC_CMD_NULL   = 8'h00,
        FCC_CMD_READ   = 8'h01,
        FCC_CMD_WRITE  = 8'h02,
        FCC_CMD_ERWR   = 8'h03,
        FCC_CMD_VERIFY = 8'h04,
        FCC_CMD_PERASE = 8'h05,
        FCC_CMD_MERASE = 8'h06,
        FCC_CMD_SIG    = 8'h0B,
        FCC_CMD_PROT   = 8'h0C,
        FCC_CMD_PING   = 8'h0F
    } fcc_cmd_t;
    // ==========================================
    // timing at 10 MHz
    localparam int FCC_CLK_HZ     = 10_000_000;
    localparam int FCC_WRITE_US   = 50;
    localparam int FCC_ERWR_MS    = 24;
    localparam int FCC_WRITE_CYC  = FCC_WRITE_US * (FCC_CLK_HZ / 1_000_000);
    localparam int FCC_ERWR_CYC   = FCC_ERWR_MS * (FCC_CLK_HZ / 1000);
    localparam int FCC_SIG_CYC    = 16389;
    // ==========================================
    // bus carriers
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [31:0] addr;
        logic [31:0] wdata;
    } fcc_bus_req_t;
    typedef struct packed {
        logic        we;
        logic [13:0] addr;
        logic [15:0] wdata;
    } fcc_mem_req_t;
endpackage : fcc_pkg

// [fcc_mem.sv]
// module: flash array model storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module fcc_mem
    import fcc_pkg::*;
(
    input  wire logic          core_clk,
    input  wire fcc_mem_req_t  req,
    output logic [15:0]        rdata
);
    // ==========================================
    // storage; no reset so it maps onto a plain ram
    logic [15:0] mem [0:(1<<FCC_AW)-1];

    always_ff @(posedge core_clk) begin
        if (req.we) begin
            mem[req.addr] <= req.wdata;
        end
        rdata <= mem[req.addr];
    end
endmodule : fcc_mem
`default_nettype wire

// [fcc_linear_feedback_shifter.sv]
// module: 24-bit signature shifter
`timescale 1ns/1ps
`default_nettype none
module fcc_linear_feedback_shifter
    import fcc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        start,
    input  wire logic        step,
    input  wire logic [15:0] din,
    output logic [23:0]      sig
);
    logic [23:0] sig_reg;
    logic [23:0] sig_next;

    // ==========================================
    // shift: taps 24,23,22,17 folded with data
    always_comb begin
        sig_next = sig_reg;
        if (start) begin
            sig_next = FCC_SIG_RST;
        end else if (step) begin
            sig_next = {sig_reg[22:0], sig_reg[23] ^ sig_reg[22] ^ sig_reg[21] ^ sig_reg[16]}
                       ^ {8'h00, din};
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sig_reg <= FCC_SIG_RST;
        end else begin
            sig_reg <= sig_next;
        end
    end

    assign sig = sig_reg;
endmodule : fcc_linear_feedback_shifter
`default_nettype wire

// [fcc_ctrl.sv]
// module: flash command controller top with memory-mapped registers
// Function
// R01: irq flag set on completion if enabled
// R02: busy flag follows controller activity
// R03: fail flag set on failure, read-clear
// R04: pass flag set on success, read-clear
// R05: mode bit 4 enables completion interrupt
// R06: mode bit 3 gates erase and write
// R07: software writes mode bits 8,7:5,2:0 correctly
// R08: read command loads data register
// R09: write programs data, busy about 50 us
// R10: erase page then write, about 24 ms
// R11: verify compares, pass or fail flag
// R12: page erase clears the addressed page
// R13: mass erase clears user region only
// R14: signature over flash, 16389 cycles
// R15: protect saves value once only
// R16: ping does nothing but interrupts; the code also sets the pass flag on completion
// R17: command reads 0x07 after codes 0-6
// R18: address above 0x77FF aborts access
// R19: data register holds 16-bit value
// R20: erase pages are 512 bytes
// R21: reserved codes do nothing
// R22: commands ignored while busy
`timescale 1ns/1ps
`default_nettype none
module fcc_ctrl
    import fcc_pkg::*;
(
    input  wire logic          core_clk,
    input  wire logic          rst_b,
    input  wire fcc_bus_req_t  bus,
    output logic [31:0]        rdata,
    output logic               abort,
    output logic               irq
);
    // ==========================================
    // state
    typedef enum logic [2:0] {
        FCC_IDLE  = 3'b000,
        FCC_WAIT  = 3'b001,
        FCC_RDEND = 3'b010,
        FCC_ERASE = 3'b011,
        FCC_SIGN  = 3'b100,
        FCC_DONE  = 3'b101
    } fcc_state_t;

    fcc_state_t  state_reg,   state_next;
    logic [15:0] mode_reg,    mode_next;
    logic [7:0]  cmd_reg,     cmd_next;
    logic [15:0] data_reg,    data_next;
    logic [15:0] addr_reg,    addr_next;
    logic [3:0]  stat_reg,    stat_next;
    logic [31:0] prot_reg,    prot_next;
    logic        prot_done_reg, prot_done_next;
    logic [31:0] prot_nv_reg, prot_nv_next;
    logic [23:0] sigv_reg,    sigv_next;
    logic [17:0] cnt_reg,     cnt_next;
    logic [13:0] ptr_reg,     ptr_next;
    logic        pass_reg,    pass_next;
    logic [31:0] rdata_next;
    logic        abort_next;
    logic        irq_next;
    fcc_mem_req_t mreq;
    logic [15:0] mrdata;
    logic        lf_start;
    logic        lf_step;
    logic [23:0] lf_sig;

    // ==========================================
    // helpers
    function automatic logic in_range(input logic [15:0] a);
        in_range = (a <= FCC_ADDR_MAX);
    endfunction : in_range

    function automatic logic [13:0] word_of(input logic [15:0] a);
        word_of = a[14:1];
    endfunction : word_of

    function automatic logic [13:0] page_base(input logic [15:0] a);
        page_base = {a[14:9], {FCC_PAGE_BITS{1'b0}}}; // [R20]
    endfunction : page_base

    function automatic logic needs_wren(input logic [7:0] c);
        needs_wren = (c == FCC_CMD_WRITE) || (c == FCC_CMD_ERWR) || (c == FCC_CMD_PERASE)
                     || (c == FCC_CMD_MERASE) || (c == FCC_CMD_PROT);
    endfunction : needs_wren

    // ==========================================
    // submodules
    fcc_mem u_mem (
        .core_clk (core_clk),
        .req      (mreq),
        .rdata    (mrdata)
    );

    fcc_linear_feedback_shifter u_linear_feedback_shifter (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .start    (lf_start),
        .step     (lf_step),
        .din      (mrdata),
        .sig      (lf_sig)
    );

    // ==========================================
    // next-state logic
    always_comb begin
        logic busy;
        logic ok;
        logic fin;
        busy           = 1'b0;
        ok             = 1'b0;
        fin            = 1'b0;
        state_next     = state_reg;
        mode_next      = mode_reg;
        cmd_next       = cmd_reg;
        data_next      = data_reg;
        addr_next      = addr_reg;
        stat_next      = stat_reg;
        prot_next      = prot_reg;
        prot_done_next = prot_done_reg;
        prot_nv_next   = prot_nv_reg;
        sigv_next      = sigv_reg;
        cnt_next       = cnt_reg;
        ptr_next       = ptr_reg;
        pass_next      = pass_reg;
        rdata_next     = 32'h00000000;
        abort_next     = 1'b0;
        mreq.we        = 1'b0;
        mreq.addr      = word_of(addr_reg);
        mreq.wdata     = data_reg;
        lf_start       = 1'b0;
        lf_step        = 1'b0;
        busy           = (state_reg != FCC_IDLE);

        // bus reads; status read clears its sticky flags
        if (bus.rd) begin
            case (bus.addr)
                FCC_STATUS_ADDR: begin
                    rdata_next = {28'h0000000, stat_reg[3], busy, stat_reg[1:0]}; // [R02]
                    stat_next  = 4'h0; // [R01] [R03] [R04]
                end
                FCC_MODE_ADDR: rdata_next = {16'h0000, mode_reg};
                FCC_CMD_ADDR:  rdata_next = {24'h000000, cmd_reg};
                FCC_DATA_ADDR: rdata_next = {16'h0000, data_reg}; // [R19]
                FCC_ADDR_ADDR: rdata_next = {16'h0000, addr_reg};
                FCC_SIG_ADDR:  rdata_next = {8'h00, sigv_reg};
                FCC_PROT_ADDR: rdata_next = prot_reg;
                default:       rdata_next = 32'h00000000;
            endcase
        end

        // bus writes; controller registers frozen while busy
        if (bus.wr && !busy) begin // [R22]
            case (bus.addr)
                FCC_MODE_ADDR: mode_next = bus.wdata[15:0]; // [R07]
                FCC_DATA_ADDR: data_next = bus.wdata[15:0]; // [R19]
                FCC_ADDR_ADDR: begin
                    addr_next  = bus.wdata[15:0];
                    abort_next = !in_range(bus.wdata[15:0]); // [R18]
                end
                FCC_PROT_ADDR: prot_next = bus.wdata;
                FCC_CMD_ADDR: begin
                    cmd_next = bus.wdata[7:0];
                    cnt_next = 18'h00000;
                    ptr_next = 14'h0000;
                    if ((bus.wdata[7:0] <= FCC_CMD_MERASE) && (bus.wdata[7:0] != FCC_CMD_NULL)
                        && !in_range(addr_reg) && (bus.wdata[7:0] != FCC_CMD_MERASE)) begin
                        abort_next = 1'b1; // [R18]
                        cmd_next   = FCC_CMD_RST;
                    end else if (needs_wren(bus.wdata[7:0]) && !mode_reg[FCC_MD_WREN]) begin
                        pass_next  = 1'b0; // [R06]
                        state_next = FCC_DONE;
                    end else begin
                        case (bus.wdata[7:0])
                            FCC_CMD_READ, FCC_CMD_VERIFY: state_next = FCC_RDEND; // [R08] [R11]
                            FCC_CMD_WRITE: state_next = FCC_WAIT; // [R09]
                            FCC_CMD_ERWR, FCC_CMD_PERASE, FCC_CMD_MERASE: begin
                                ptr_next   = (bus.wdata[7:0] == FCC_CMD_MERASE) ? 14'h0000
                                             : page_base(addr_reg); // [R12] [R13]
                                state_next = FCC_ERASE;
                            end
                            FCC_CMD_SIG: begin
                                lf_start   = 1'b1; // [R14]
                                state_next = FCC_SIGN;
                            end
                            FCC_CMD_PROT: begin
                                pass_next  = !prot_done_reg; // [R15]
                                state_next = FCC_DONE;
                            end
                            FCC_CMD_PING: begin
                                pass_next  = 1'b1; // [R16]
                                state_next = FCC_DONE;
                            end
                            FCC_CMD_NULL: cmd_next = FCC_CMD_RST; // [R17]
                            default: state_next = FCC_IDLE; // [R21]
                        endcase
                    end
                end
                default: ;
            endcase
        end

        // command execution
        case (state_reg)
            FCC_IDLE: ;
            FCC_RDEND: begin
                // memory read data is ready one cycle after the address
                if (cmd_reg == FCC_CMD_READ) begin
                    data_next = mrdata; // [R08]
                    pass_next = 1'b1;
                end else begin
                    pass_next = (mrdata == data_reg); // [R11]
                end
                state_next = FCC_DONE;
            end
            FCC_WAIT: begin
                if (cnt_reg == 18'(FCC_WRITE_CYC - 1)) begin
                    mreq.we    = 1'b1; // [R09]
                    pass_next  = 1'b1;
                    state_next = FCC_DONE;
                end else begin
                    cnt_next = cnt_reg + 18'h00001;
                end
            end
            FCC_ERASE: begin
                // erase one word a cycle; erase-write then holds out its total busy time
                mreq.addr = ptr_reg;
                mreq.wdata = FCC_ERASED;
                if (cmd_reg == FCC_CMD_MERASE) begin
                    mreq.we = (ptr_reg < 14'(FCC_USER_WORDS)); // [R13]
                end else begin
                    mreq.we = (ptr_reg[13:8] == addr_reg[14:9]); // [R12] [R20]
                end
                if (mreq.we) begin
                    ptr_next = ptr_reg + 14'h0001;
                end
                if (cmd_reg == FCC_CMD_ERWR) begin
                    if (cnt_reg == 18'(FCC_ERWR_CYC - 1)) begin
                        mreq.we    = 1'b1; // [R10]
                        mreq.addr  = word_of(addr_reg);
                        mreq.wdata = data_reg;
                        pass_next  = 1'b1;
                        state_next = FCC_DONE;
                    end else begin
                        cnt_next = cnt_reg + 18'h00001;
                    end
                end else if (!mreq.we) begin
                    if (cmd_reg == FCC_CMD_MERASE) begin
                        prot_done_next = 1'b0; // [R15]
                        prot_nv_next   = FCC_PROT_RST;
                    end
                    pass_next  = 1'b1;
                    state_next = FCC_DONE;
                end
            end
            FCC_SIGN: begin
                mreq.addr = ptr_reg;
                lf_step   = (cnt_reg != 18'h00000);
                ptr_next  = ptr_reg + 14'h0001;
                if (cnt_reg == 18'(FCC_SIG_CYC - 1)) begin
                    sigv_next  = lf_sig; // [R14]
                    pass_next  = 1'b1;
                    state_next = FCC_DONE;
                end else begin
                    cnt_next = cnt_reg + 18'h00001;
                end
            end
            FCC_DONE: begin
                fin = 1'b1;
                ok  = pass_reg;
                if (cmd_reg == FCC_CMD_PROT && pass_reg) begin
                    prot_done_next = 1'b1; // [R15]
                    prot_nv_next   = prot_reg;
                end
                if (cmd_reg <= FCC_CMD_MERASE) begin
                    cmd_next = FCC_CMD_RST; // [R17]
                end
                state_next = FCC_IDLE; // [R02]
            end
            default: state_next = FCC_IDLE;
        endcase

        // set wins over a simultaneous read-clear
        if (fin) begin
            if (ok) begin
                stat_next[FCC_ST_PASS] = 1'b1; // [R04]
            end else begin
                stat_next[FCC_ST_FAIL] = 1'b1; // [R03]
            end
            if (mode_reg[FCC_MD_IEN]) begin
                stat_next[FCC_ST_IRQ] = 1'b1; // [R01] [R05]
            end
        end
        irq_next = stat_next[FCC_ST_IRQ]; // [R05]
    end

    // ==========================================
    // registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg     <= FCC_IDLE;
            mode_reg      <= FCC_MODE_RST;
            cmd_reg       <= FCC_CMD_RST; // [R17]
            data_reg      <= FCC_DATA_RST;
            addr_reg      <= FCC_ADDR_RST;
            stat_reg      <= 4'h0;
            prot_reg      <= FCC_PROT_RST;
            prot_done_reg <= 1'b0;
            prot_nv_reg   <= FCC_PROT_RST;
            sigv_reg      <= FCC_SIG_RST;
            cnt_reg       <= 18'h00000;
            ptr_reg       <= 14'h0000;
            pass_reg      <= 1'b0;
            rdata         <= 32'h00000000;
            abort         <= 1'b0;
            irq           <= 1'b0;
        end else begin
            state_reg     <= state_next;
            mode_reg      <= mode_next;
            cmd_reg       <= cmd_next;
            data_reg      <= data_next;
            addr_reg      <= addr_next;
            stat_reg      <= stat_next;
            prot_reg      <= prot_next;
            prot_done_reg <= prot_done_next;
            prot_nv_reg   <= prot_nv_next;
            sigv_reg      <= sigv_next;
            cnt_reg       <= cnt_next;
            ptr_reg       <= ptr_next;
            pass_reg      <= pass_next;
            rdata         <= rdata_next;
            abort         <= abort_next;
            irq           <= irq_next;
        end
    end
endmodule : fcc_ctrl
`default_nettype wire

// [fcc_ctrl_asserts.sv]
// checker: port-level properties of the flash command controller
`timescale 1ns/1ps
`default_nettype none
module fcc_ctrl_asserts
    import fcc_pkg::*;
(
    input wire logic          core_clk,
    input wire logic          rst_b,
    input wire fcc_bus_req_t  bus,
    input wire logic [31:0]   rdata,
    input wire logic          abort,
    input wire logic          irq
);
    // ==========================================
    // helpers
    logic rd_st;
    assign rd_st = bus.rd && (bus.addr == FCC_STATUS_ADDR);
    default clocking dclk @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // ==========================================
    // status, interrupt and register readback
    AST_IRQ_MIRROR: assert property (
        $past(rd_st) |-> rdata[3] == $past(irq)) else $error("status read shows wrong irq bit");
    AST_IRQ_HOLD: assert property (
        irq && !rd_st |=> irq) else $error("irq dropped without status read");
    // three quiet cycles first, so no command can sit in its one-cycle pre-busy gap
    AST_FLAGS_CLEAR: assert property (
        (!bus.wr)[*3] ##1 (rd_st && !bus.wr) ##1 (rdata[2] == 1'b0 && !bus.wr) ##1 rd_st
        |=> (rdata[3:0] == 4'h0 && !irq)) else $error("flags survive a status read");
    AST_DATA_RB: assert property (
        (!bus.wr)[*3] ##1 rd_st ##1 (rdata[2] == 1'b0 && !bus.wr)
        ##1 (bus.wr && bus.addr == FCC_DATA_ADDR) ##1 !bus.wr ##1 (bus.rd && bus.addr == FCC_DATA_ADDR)
        |=> rdata[15:0] == $past(bus.wdata[15:0], 3)) else $error("data register readback wrong");
    AST_MODE_RB: assert property (
        (!bus.wr)[*3] ##1 rd_st ##1 (rdata[2] == 1'b0 && !bus.wr)
        ##1 (bus.wr && bus.addr == FCC_MODE_ADDR) ##1 !bus.wr ##1 (bus.rd && bus.addr == FCC_MODE_ADDR)
        |=> rdata[4:3] == $past(bus.wdata[4:3], 3)) else $error("mode enable bits readback wrong");
    // ==========================================
    // address range abort
    AST_ABORT_HIGH: assert property (
        bus.wr && bus.addr == FCC_ADDR_ADDR && bus.wdata[15:0] > FCC_ADDR_MAX |=> abort)
        else $error("no abort on out-of-range address");
    AST_ABORT_LOW: assert property (
        bus.wr && bus.addr == FCC_ADDR_ADDR && bus.wdata[15:0] <= FCC_ADDR_MAX |=> !abort)
        else $error("abort on valid address");
    AST_ABORT_CAUSE: assert property (
        abort |-> $past(bus.wr) && ($past(bus.addr) == FCC_ADDR_ADDR || $past(bus.addr) == FCC_CMD_ADDR))
        else $error("abort without a causing write");
endmodule : fcc_ctrl_asserts
`default_nettype wire

// [fcc_host.sv]
// partner: processor-side master issuing register accesses
`timescale 1ns/1ps
`default_nettype none
module fcc_host
    import fcc_pkg::*;
(
    input  wire logic         core_clk,
    input  wire logic [31:0]  rdata,
    output var fcc_bus_req_t  bus
);
    // ==========================================
    // bus cycles: strobe for one edge, then lines are scrambled, not left stale
    initial bus = '0;
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        @(posedge core_clk);
        bus <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
        @(posedge core_clk);
        bus <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~v};
    endtask : wr
    task automatic rd(input logic [31:0] a, output logic [31:0] v);
        @(posedge core_clk);
        bus <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: ~bus.wdata};
        @(posedge core_clk);
        bus <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: bus.wdata};
        #1 v = rdata;
    endtask : rd
    // reserved bits kept as software must write them
    function automatic logic [31:0] mode_word(input logic ien, input logic wren);
        return {16'h0000, 7'h00, 1'b1, 3'b000, ien, wren, 3'b000};
    endfunction : mode_word
endmodule : fcc_host
`default_nettype wire

// [tb.sv]
// testbench: register-level scenarios against a behavioural flash model
`timescale 1ns/1ps
`default_nettype none
module tb
    import fcc_pkg::*;
;
    // ==========================================
    // signals and model state
    logic          core_clk;
    logic          rst_b;
    fcc_bus_req_t  bus;
    logic [31:0]   rdata;
    logic          abort;
    logic          irq;
    int            bad_count;
    int            n_compared;
    logic [15:0]   fl [int];
    logic [15:0]   cur_a, cur_d, ra, rv, rv2;
    logic          ien, wren, prot;
    logic [31:0]   seed, d;
    logic [7:0]    rsv_codes [7] = '{8'h00, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0D, 8'h0E};

    fcc_ctrl u_fcc_ctrl (.core_clk(core_clk), .rst_b(rst_b), .bus(bus), .rdata(rdata), .abort(abort), .irq(irq));
    fcc_host u_fcc_host (.core_clk(core_clk), .rdata(rdata), .bus(bus));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // ==========================================
    // helpers
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict;
        $display("mismatches %0d compared %0d", bad_count, n_compared);
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict
    task automatic set_mode(input logic i, input logic w);
        ien = i;
        wren = w;
        u_fcc_host.wr(FCC_MODE_ADDR, u_fcc_host.mode_word(i, w));
        u_fcc_host.rd(FCC_MODE_ADDR, d);
        chk(d & 32'h18, {27'h0, i, w, 3'h0});
    endtask : set_mode
    task automatic set_ad(input logic [15:0] a, input logic [15:0] v);
        cur_a = a;
        cur_d = v;
        u_fcc_host.wr(FCC_DATA_ADDR, {16'h0000, v});
        u_fcc_host.rd(FCC_DATA_ADDR, d);
        chk(d & 32'hFFFF, {16'h0000, v});
        u_fcc_host.wr(FCC_ADDR_ADDR, {16'h0000, a});
    endtask : set_ad
    // issue one command, poll busy, compare flags with the model
    task automatic run_cmd(input logic [7:0] c);
        logic [3:0] ex, m;
        int         n, lo;
        logic       rsv;
        rsv = c inside {8'h00, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0D, 8'h0E};
        m = (c == 8'h0F) ? 4'b1000 : 4'hF;
        lo = 0;
        ex = 4'b0001;
        case (c)
            8'h01: cur_d = fl[cur_a];
            8'h02: if (wren) begin
                fl[cur_a] = cur_d;
                lo = FCC_WRITE_CYC;
            end else begin
                ex = 4'b0010;
            end
            8'h03: ex = 4'b0010; // only run locked: a full erase-write outlasts the run
            8'h04: ex = (fl[cur_a] === cur_d) ? 4'b0001 : 4'b0010;
            8'h05, 8'h06: if (wren) begin
                foreach (fl[k]) if (k[15:9] == cur_a[15:9] || c == 8'h06) fl[k] = FCC_ERASED;
                if (c == 8'h06) begin
                    prot = 1'b0;
                    lo = FCC_USER_WORDS;
                end
            end else begin
                ex = 4'b0010;
            end
            8'h0B: lo = FCC_SIG_CYC;
            8'h0C: begin
                ex = (wren && !prot) ? 4'b0001 : 4'b0010;
                prot = prot | wren;
            end
            default: ;
        endcase
        if (rsv) ex = 4'b0000;
        else ex[3] = ien;
        u_fcc_host.wr(FCC_CMD_ADDR, {24'h0, c});
        repeat (4) @(posedge core_clk);
        if (lo > 0) u_fcc_host.wr(FCC_DATA_ADDR, {16'h0000, ~cur_d});
        n = 0;
        do begin
            u_fcc_host.rd(FCC_STATUS_ADDR, d);
            n++;
        end while (d[2] === 1'b1 && n < 20000);
        chk({28'h0, d[3:0] & m}, {28'h0, ex & m});
        if (lo > 0) chk({31'h0, n * 2 + 12 >= lo && n * 2 <= lo + 12}, 32'h1);
        u_fcc_host.rd(FCC_STATUS_ADDR, d);
        chk({d[3:0], 3'h0, irq}, 8'h00);
        if (c <= 8'h06 || rsv) begin
            u_fcc_host.rd(FCC_CMD_ADDR, d);
            chk(d & 32'hFF, (c > 8'h06) ? {24'h0, c} : 32'h07);
        end
        u_fcc_host.rd(FCC_DATA_ADDR, d);
        chk(d & 32'hFFFF, {16'h0000, cur_d});
        u_fcc_host.rd(FCC_STATUS_ADDR, d);
    endtask : run_cmd
    // ==========================================
    // watchdog: whole sequence needs about 34000 cycles
    initial begin
        repeat (60000) @(posedge core_clk);
        bad_count++;
        give_verdict();
    end
    // ==========================================
    // main sequence
    initial begin
        bad_count = 0;
        n_compared = 0;
        prot = 1'b0;
        ien = 1'b0;
        wren = 1'b0;
        rst_b = 1'b0;
        seed = nxt(32'h2EDA);
        ra = (seed[15:0] % 16'h7600) & 16'hFFFE;
        seed = nxt(seed);
        rv = seed[15:0];
        seed = nxt(seed);
        rv2 = seed[15:0];
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        u_fcc_host.rd(FCC_MODE_ADDR, d);
        chk(d & 32'hFFFF, 32'h0);
        u_fcc_host.rd(FCC_CMD_ADDR, d);
        chk(d & 32'hFF, 32'h07);
        u_fcc_host.rd(FCC_ADDR_ADDR, d);
        chk(d & 32'hFFFF, 32'h0);
        u_fcc_host.rd(FCC_STATUS_ADDR, d);
        chk(d & 32'hF, 32'h0);
        set_mode(1'b0, 1'b0);
        set_ad(ra, rv);
        run_cmd(8'h02);
        run_cmd(8'h03);
        set_mode(1'b1, 1'b1);
        set_ad(ra + 16'h0200, rv2);
        run_cmd(8'h05);
        run_cmd(8'h02);
        set_ad(ra, rv);
        run_cmd(8'h05);
        run_cmd(8'h02);
        run_cmd(8'h04);
        set_ad(ra, ~rv);
        run_cmd(8'h04);
        set_ad(ra, 16'h0000);
        run_cmd(8'h01);
        run_cmd(8'h05);
        run_cmd(8'h01);
        set_ad(ra + 16'h0200, 16'h0000);
        run_cmd(8'h01);
        run_cmd(8'h0F);
        set_mode(1'b0, 1'b1);
        run_cmd(8'h0F);
        set_mode(1'b1, 1'b1);
        foreach (rsv_codes[i]) run_cmd(rsv_codes[i]);
        run_cmd(8'h0B);
        run_cmd(8'h0C);
        run_cmd(8'h0C);
        run_cmd(8'h06);
        run_cmd(8'h01);
        run_cmd(8'h0C);
        u_fcc_host.wr(FCC_ADDR_ADDR, 32'h0000_7800);
        #1 chk({31'h0, abort}, 32'h1);
        u_fcc_host.wr(FCC_ADDR_ADDR, 32'h0000_77FF);
        #1 chk({31'h0, abort}, 32'h0);
        u_fcc_host.rd(FCC_ADDR_ADDR, d);
        chk(d & 32'hFFFF, 32'h77FF);
        give_verdict();
    end
endmodule : tb
bind fcc_ctrl fcc_ctrl_asserts u_fcc_ctrl_asserts (.core_clk(core_clk), .rst_b(rst_b), .bus(bus),
    .rdata(rdata), .abort(abort), .irq(irq));
`default_nettype wire
